// ===== hdl/gpcf_pkg.sv
// Package: register map, widths and carrier structs for ports C to F
package gpcf_pkg;

  localparam int          GPCF_ADDR_W      = 16;
  localparam int          GPCF_DATA_W      = 8;

  // Register offsets
  localparam logic [15:0] GPCF_OFS_C_DATA  = 16'h0002;
  localparam logic [15:0] GPCF_OFS_D_DATA  = 16'h0003;
  localparam logic [15:0] GPCF_OFS_E_DATA  = 16'h0008;
  localparam logic [15:0] GPCF_OFS_F_DATA  = 16'h0009;
  localparam logic [15:0] GPCF_OFS_C_DIR   = 16'h0006;
  localparam logic [15:0] GPCF_OFS_E_DIR   = 16'h000c;
  localparam logic [15:0] GPCF_OFS_F_DIR   = 16'h000d;

  // Port widths
  localparam int          GPCF_C_W         = 7;
  localparam int          GPCF_D_W         = 7;
  localparam int          GPCF_E_W         = 8;
  localparam int          GPCF_F_W         = 6;

  // Reset values
  localparam logic [6:0]  GPCF_C_DIR_RST   = 7'h00;
  localparam logic [7:0]  GPCF_E_DIR_RST   = 8'h00;
  localparam logic [5:0]  GPCF_F_DIR_RST   = 6'h00;
  localparam logic [7:0]  GPCF_RDATA_RST   = 8'h00;

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } gpcf_bus_t;

  // Peripheral override of one port: ownership, enable, value
  typedef struct packed {
    logic [7:0] own;
    logic [7:0] oe;
    logic [7:0] val;
  } gpcf_ovr_t;

  // Pin drive of one port
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] val;
  } gpcf_drv_t;

endpackage

// ===== hdl/gpcf_ports.sv
// GPIO ports C, D, E and F with direction registers and peripheral overrides
//
// Contract
// - Reset clears port C direction bits.
// - Port C read: latch if output, else pin.
// - Data writes always update the latch.
// - Input pin: write changes only the latch.
// - Port D: seven inputs, no drivers, no direction.
// - Port D read always returns pins.
// - Port D latch write-only, kept over reset.
// - Port E eight bits, timer and serial shared.
// - Timer-owned E pin: direction only picks read.
// - Direction one drives pin, zero floats it.
// - Reset clears port E direction bits.
// - Port E read: latch if output, else pin.
// - Port F six bits, SPI and serial shared.
// - Port F latch kept over reset.
// - Serial-owned F pin: direction only picks read.
// - Reset clears port F direction bits.
// - Port F read: latch if output, else pin.
// - Direction registers read back last write.
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps

module gpcf_ports (
  input  wire logic               clk_in,
  input  wire logic               reset_in,
  input  wire gpcf_pkg::gpcf_bus_t bus_in,
  output logic [7:0]              rdata_out,
  input  wire logic [6:0]         port_c_pin_in,
  input  wire logic [6:0]         port_d_pin_in,
  input  wire logic [7:0]         port_e_pin_in,
  input  wire logic [5:0]         port_f_pin_in,
  input  wire gpcf_pkg::gpcf_ovr_t port_c_ovr_in,
  input  wire gpcf_pkg::gpcf_ovr_t port_e_ovr_in,
  input  wire gpcf_pkg::gpcf_ovr_t port_f_ovr_in,
  output logic [6:0]              port_c_pin_out,
  output logic [6:0]              port_c_pin_oe_out,
  output logic [7:0]              port_e_pin_out,
  output logic [7:0]              port_e_pin_oe_out,
  output logic [5:0]              port_f_pin_out,
  output logic [5:0]              port_f_pin_oe_out,
  output logic [6:0]              port_d_level_out
);
  import gpcf_pkg::*;

  // Pin synchronisers: three stages, change taken when stages 2 and 3 agree
  localparam int PIN_W = GPCF_C_W + GPCF_D_W + GPCF_E_W + GPCF_F_W;

  logic [PIN_W-1:0] pin_s1_reg;
  logic [PIN_W-1:0] pin_s2_reg;
  logic [PIN_W-1:0] pin_s3_reg;
  logic [PIN_W-1:0] pin_lvl_reg;
  logic [PIN_W-1:0] pin_raw;

  assign pin_raw = {port_f_pin_in, port_e_pin_in,
                    port_d_pin_in, port_c_pin_in};

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_s3_reg <= '0;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_filt
      always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
          pin_lvl_reg[gi] <= 1'b0;
        end else if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
          pin_lvl_reg[gi] <= pin_s3_reg[gi];
        end
      end
    end
  endgenerate

  logic [6:0] c_pin;
  logic [6:0] d_pin;
  logic [7:0] e_pin;
  logic [5:0] f_pin;

  assign c_pin = pin_lvl_reg[6:0];
  assign d_pin = pin_lvl_reg[13:7];
  assign e_pin = pin_lvl_reg[21:14];
  assign f_pin = pin_lvl_reg[27:22];

  // Write decode
  function automatic logic hit(input gpcf_bus_t b, input logic [15:0] ofs);
    hit = b.wr && (b.addr == ofs);
  endfunction

  // Read mux: latch where direction is 1, pin where 0
  function automatic logic [7:0] rd_mix(input logic [7:0] dir,
                                        input logic [7:0] lat,
                                        input logic [7:0] pin);
    rd_mix = (dir & lat) | (~dir & pin);
  endfunction

  // Data latches: no reset, written whatever the direction
  logic [6:0] c_lat_reg;
  logic [6:0] d_lat_reg;
  logic [7:0] e_lat_reg;
  logic [5:0] f_lat_reg;

  always_ff @(posedge clk_in) begin
    if (hit(bus_in, GPCF_OFS_C_DATA)) begin
      c_lat_reg <= bus_in.wdata[6:0];
    end
    if (hit(bus_in, GPCF_OFS_D_DATA)) begin
      d_lat_reg <= bus_in.wdata[6:0];
    end
    if (hit(bus_in, GPCF_OFS_E_DATA)) begin
      e_lat_reg <= bus_in.wdata;
    end
    if (hit(bus_in, GPCF_OFS_F_DATA)) begin
      f_lat_reg <= bus_in.wdata[5:0];
    end
  end

  // Direction registers
  logic [6:0] c_dir_reg;
  logic [7:0] e_dir_reg;
  logic [5:0] f_dir_reg;

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      c_dir_reg <= GPCF_C_DIR_RST;
      e_dir_reg <= GPCF_E_DIR_RST;
      f_dir_reg <= GPCF_F_DIR_RST;
    end else begin
      if (hit(bus_in, GPCF_OFS_C_DIR)) begin
        c_dir_reg <= bus_in.wdata[6:0];
      end
      if (hit(bus_in, GPCF_OFS_E_DIR)) begin
        e_dir_reg <= bus_in.wdata;
      end
      if (hit(bus_in, GPCF_OFS_F_DIR)) begin
        f_dir_reg <= bus_in.wdata[5:0];
      end
    end
  end

  // Read data, one cycle after the strobe, zero otherwise
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = GPCF_RDATA_RST;
    if (bus_in.rd) begin
      unique case (bus_in.addr)
        GPCF_OFS_C_DATA:
          rdata_next = rd_mix({1'b0, c_dir_reg}, {1'b0, c_lat_reg},
                              {1'b0, c_pin});
        GPCF_OFS_D_DATA: rdata_next = {1'b0, d_pin};
        GPCF_OFS_E_DATA:
          rdata_next = rd_mix(e_dir_reg, e_lat_reg, e_pin);
        GPCF_OFS_F_DATA:
          rdata_next = rd_mix({2'b00, f_dir_reg}, {2'b00, f_lat_reg},
                              {2'b00, f_pin});
        GPCF_OFS_C_DIR:  rdata_next = {1'b0, c_dir_reg};
        GPCF_OFS_E_DIR:  rdata_next = e_dir_reg;
        GPCF_OFS_F_DIR:  rdata_next = {2'b00, f_dir_reg};
        default:         rdata_next = GPCF_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_out <= GPCF_RDATA_RST;
    end else begin
      rdata_out <= rdata_next;
    end
  end

  // Pin drivers: owning peripheral first, else direction and latch
  function automatic gpcf_drv_t drive(input logic [7:0] dir,
                                      input logic [7:0] lat,
                                      input gpcf_ovr_t  o);
    drive.oe  = (o.own & o.oe) | (~o.own & dir);
    drive.val = (o.own & o.val) | (~o.own & lat);
  endfunction

  gpcf_drv_t c_drv;
  gpcf_drv_t e_drv;
  gpcf_drv_t f_drv;

  assign c_drv = drive({1'b0, c_dir_reg}, {1'b0, c_lat_reg}, port_c_ovr_in);
  assign e_drv = drive(e_dir_reg, e_lat_reg, port_e_ovr_in);
  assign f_drv = drive({2'b00, f_dir_reg}, {2'b00, f_lat_reg},
                       port_f_ovr_in);

  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      port_c_pin_oe_out <= '0;
      port_e_pin_oe_out <= '0;
      port_f_pin_oe_out <= '0;
      port_c_pin_out    <= '0;
      port_e_pin_out    <= '0;
      port_f_pin_out    <= '0;
    end else begin
      port_c_pin_oe_out <= c_drv.oe[6:0];
      port_e_pin_oe_out <= e_drv.oe;
      port_f_pin_oe_out <= f_drv.oe[5:0];
      port_c_pin_out    <= c_drv.val[6:0];
      port_e_pin_out    <= e_drv.val;
      port_f_pin_out    <= f_drv.val[5:0];
    end
  end

  // Port D has no driver; filtered level goes to the motor PWM side
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      port_d_level_out <= '0;
    end else begin
      port_d_level_out <= d_pin;
    end
  end

endmodule

// ===== tb/gpcf_pin_model.sv
// Partner: pad that resolves device drive against the board level
`timescale 1ns/100ps
module gpcf_pin_model #(parameter int W = 8) (
  input  wire logic [W-1:0] out_in,
  input  wire logic [W-1:0] oe_in,
  input  wire logic [W-1:0] ext_in,
  output logic      [W-1:0] level_out
);
  // Driven bits follow the device, floating bits the board
  always_comb level_out = (out_in & oe_in) | (ext_in & ~oe_in);
endmodule

// ===== tb/gpcf_ports_sva.sv
// Checker: assertions on the ports of gpcf_ports
`timescale 1ns/100ps
module gpcf_ports_sva (
  input wire logic                clk_in,
  input wire logic                reset_in,
  input wire gpcf_pkg::gpcf_bus_t bus_in,
  input wire logic [7:0]          rdata_out,
  input wire logic [6:0]          port_d_pin_in,
  input wire gpcf_pkg::gpcf_ovr_t port_e_ovr_in,
  input wire gpcf_pkg::gpcf_ovr_t port_f_ovr_in,
  input wire logic [7:0]          port_e_pin_out,
  input wire logic [7:0]          port_e_pin_oe_out,
  input wire logic [5:0]          port_f_pin_out,
  input wire logic [5:0]          port_f_pin_oe_out
);
  import gpcf_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);
  sequence wr_at(a); bus_in.wr && bus_in.addr == a; endsequence
  sequence rd_at(a); bus_in.rd && bus_in.addr == a; endsequence
  chk_dir_reset: assert property (
    $fell(reset_in) && port_e_ovr_in.own == 0 && port_f_ovr_in.own == 0
    |-> ##1 port_e_pin_oe_out == 0 && port_f_pin_oe_out == 0)
    else $error("pin driven after reset");
  chk_dir_drive: assert property (
    wr_at(GPCF_OFS_F_DIR) ##1 port_f_ovr_in.own[5:0] == 0
    |=> port_f_pin_oe_out == $past(bus_in.wdata[5:0], 2))
    else $error("port f enable differs");
  chk_e_owned: assert property (
    &port_e_ovr_in.own |=> port_e_pin_oe_out == $past(port_e_ovr_in.oe)
    && port_e_pin_out == $past(port_e_ovr_in.val)) else $error("e owner");
  chk_f_owned: assert property (
    &port_f_ovr_in.own[5:0] |=> port_f_pin_out ==
    $past(port_f_ovr_in.val[5:0])) else $error("f owner");
  chk_dir_rdback: assert property (
    wr_at(GPCF_OFS_F_DIR) ##1 rd_at(GPCF_OFS_F_DIR) |=>
    rdata_out == {2'b00, $past(bus_in.wdata[5:0], 2)}) else $error("dir");
  chk_d_pin_read: assert property (
    $stable(port_d_pin_in)[*7] ##0 rd_at(GPCF_OFS_D_DATA) |=>
    rdata_out == {1'b0, $past(port_d_pin_in)}) else $error("d read");
  chk_latch_read: assert property (
    bus_in.wr && bus_in.addr == GPCF_OFS_E_DIR && bus_in.wdata == 8'hff
    ##1 wr_at(GPCF_OFS_E_DATA) ##1 rd_at(GPCF_OFS_E_DATA) |=>
    rdata_out == $past(bus_in.wdata, 2)) else $error("e latch read");
  chk_e_drive: assert property (
    wr_at(GPCF_OFS_E_DATA) ##1 bus_in.wr && bus_in.addr == GPCF_OFS_E_DIR
    && bus_in.wdata == 8'hff ##1 port_e_ovr_in.own == 0 |=>
    port_e_pin_oe_out == 8'hff &&
    port_e_pin_out == $past(bus_in.wdata, 3)) else $error("e drive");
  cover property (&port_e_ovr_in.own);
  cover property (wr_at(GPCF_OFS_F_DIR) ##1 rd_at(GPCF_OFS_F_DIR));
  cover property (rd_at(GPCF_OFS_D_DATA));
endmodule

// ===== tb/gpcf_ports_tb.sv
// Bench: random and corner traffic on ports C to F
`timescale 1ns/100ps
module gpcf_ports_tb;
  import gpcf_pkg::*;
  logic clk_in = 0, reset_in = 1;
  gpcf_bus_t bus_in = '0;
  gpcf_ovr_t ovr [3] = '{default: '0};
  logic [7:0] ext [4] = '{default: '0}, rdata_out, l, d;
  logic [7:0] m [3] = '{8'h7f, 8'hff, 8'h3f};
  logic [15:0] da [3] = '{GPCF_OFS_C_DATA, GPCF_OFS_E_DATA, GPCF_OFS_F_DATA};
  logic [15:0] dd [3] = '{GPCF_OFS_C_DIR, GPCF_OFS_E_DIR, GPCF_OFS_F_DIR};
  wire [7:0] oe [3], po [3], lv [3];
  wire [6:0] dl;
  int err_total = 0, samples_checked = 0, seed = 74019;
  always #12.5 clk_in = ~clk_in;
  gpcf_ports i_gpcf_ports (.clk_in(clk_in), .reset_in(reset_in),
    .bus_in(bus_in), .rdata_out(rdata_out), .port_c_pin_in(lv[0][6:0]),
    .port_d_pin_in(ext[3][6:0]), .port_e_pin_in(lv[1]),
    .port_f_pin_in(lv[2][5:0]), .port_c_ovr_in(ovr[0]),
    .port_e_ovr_in(ovr[1]), .port_f_ovr_in(ovr[2]),
    .port_c_pin_out(po[0][6:0]), .port_c_pin_oe_out(oe[0][6:0]),
    .port_e_pin_out(po[1]), .port_e_pin_oe_out(oe[1]),
    .port_f_pin_out(po[2][5:0]), .port_f_pin_oe_out(oe[2][5:0]),
    .port_d_level_out(dl));
  gpcf_pin_model #(.W(7)) i_gpcf_pin_model_c (.out_in(po[0][6:0]),
    .oe_in(oe[0][6:0]), .ext_in(ext[0][6:0]), .level_out(lv[0][6:0]));
  gpcf_pin_model #(.W(8)) i_gpcf_pin_model_e (.out_in(po[1]),
    .oe_in(oe[1]), .ext_in(ext[1]), .level_out(lv[1]));
  gpcf_pin_model #(.W(6)) i_gpcf_pin_model_f (.out_in(po[2][5:0]),
    .oe_in(oe[2][5:0]), .ext_in(ext[2][5:0]), .level_out(lv[2][5:0]));
  task automatic chk(string s, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic acc(logic w, logic [15:0] a, logic [7:0] v);
    @(posedge clk_in);
    bus_in <= '{a, v, w, !w};
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge clk_in) bus_in <= '0;
  endtask
  task automatic rdc(string s, logic [15:0] a, logic [7:0] e);
    acc(0, a, 8'h00);
    idle(1);
    #1 chk(s, rdata_out, e);
  endtask
  function automatic logic [7:0] ex(int p, logic [7:0] v, logic [7:0] dr);
    return ((v & dr) | (ext[p] & ~dr)) & m[p];
  endfunction
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #1000000;
    err_total++;
    close_out;
  end
  initial begin
    repeat (16) @(posedge clk_in);
    reset_in <= 0;
    for (int p = 0; p < 3; p++)
      rdc("dir rst", dd[p], 8'h00);
    for (int i = 0; i < 10; i++)
      for (int p = 0; p < 3; p++) begin
        l = 8'($random(seed));
        d = i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($random(seed));
        acc(1, da[p], l);
        ext[p] <= 8'($random(seed));
        acc(1, dd[p], d);
        rdc("dir", dd[p], d & m[p]);
        idle(6);
        rdc("data", da[p], ex(p, l, d));
        chk("oe", oe[p] & m[p], d & m[p]);
        chk("drv", po[p] & d & m[p], l & d & m[p]);
        acc(1, dd[p], d);
        acc(1, da[p], ~l);
        rdc("input", da[p], ex(p, ~l, d));
      end
    acc(1, da[1], 8'h5a);
    acc(1, dd[1], 8'hff);
    for (int p = 0; p < 3; p++)
      ovr[p] <= {8'hff, 16'($random(seed))};
    idle(3);
    #1;
    for (int p = 0; p < 3; p++) begin
      chk("own oe", oe[p] & m[p], ovr[p].oe & m[p]);
      chk("own val", po[p] & m[p], ovr[p].val & m[p]);
    end
    rdc("own read", da[1], 8'h5a);
    idle(1);
    ovr <= '{default: '0};
    acc(1, GPCF_OFS_D_DATA, 8'h3c);
    for (int i = 0; i < 4; i++) begin
      idle(1);
      ext[3] <= 8'($random(seed));
      idle(9);
      rdc("d pin", GPCF_OFS_D_DATA, ext[3] & 8'h7f);
      chk("d level", {1'b0, dl}, ext[3] & 8'h7f);
    end
    acc(1, da[2], 8'h2b);
    acc(1, dd[2], 8'h3f);
    idle(3);
    reset_in <= 1;
    idle(2);
    reset_in <= 0;
    rdc("rst dir", dd[2], 8'h00);
    acc(1, dd[2], 8'h3f);
    rdc("keep", da[2], 8'h2b);
    close_out;
  end
endmodule
bind gpcf_ports gpcf_ports_sva i_gpcf_ports_sva (.clk_in(clk_in),
  .reset_in(reset_in), .bus_in(bus_in), .rdata_out(rdata_out),
  .port_d_pin_in(port_d_pin_in), .port_e_ovr_in(port_e_ovr_in),
  .port_f_ovr_in(port_f_ovr_in), .port_e_pin_out(port_e_pin_out),
  .port_e_pin_oe_out(port_e_pin_oe_out), .port_f_pin_out(port_f_pin_out),
  .port_f_pin_oe_out(port_f_pin_oe_out));
